// *** rtl/swr_pkg.sv ***
/*
  Shared constants and carriers for the single-wire ROM and memory front end.
  Assumes a bit-timing front end that delivers whole bytes and link events.
*/
package swr_pkg;
  // ==========================================================
  // Identity layout
  localparam int ID_BITS = 64;
  localparam int FAMILY_BITS = 8;
  localparam int SERIAL_BITS = 48;
  localparam int CRC_BITS = 8;
  localparam int CRC_COVER_BITS = 56;
  localparam logic [7:0] CRC8_POLY_REFL = 8'h8c; // x^8+x^5+x^4+1, reflected
  localparam logic [15:0] CRC16_POLY_REFL = 16'ha001;
  // ==========================================================
  // ROM function commands
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;
  localparam logic [7:0] CMD_SKIP_ID = 8'hcc;
  localparam logic [7:0] CMD_COND_SEARCH = 8'hec;
  // Memory function commands
  localparam logic [7:0] CMD_READ_MEM = 8'hf0;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;
  localparam logic [7:0] CMD_READ_STATUS = 8'haa;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;
  localparam logic [7:0] CMD_CHANNEL = 8'hf5;
  // ==========================================================
  // Memory organisation
  localparam int DATA_PAGES = 4;
  localparam int PAGE_BYTES = 32;
  localparam int DATA_BYTES = DATA_PAGES * PAGE_BYTES; // 1024 bits
  localparam int STATUS_BYTES = 8;
  localparam logic [2:0] STATUS_PWRON_ADDR = 3'h6;
  localparam logic [2:0] STATUS_LIVE_ADDR = 3'h7;
  localparam logic [7:0] OTP_ERASED = 8'hff;
  localparam logic [7:0] STATUS5_FACTORY = 8'h00;
  // Live status bit positions
  localparam int ST_POLARITY = 0;
  localparam int ST_SRC_LO = 1;
  localparam int ST_SRC_HI = 2;
  localparam int ST_CH_A = 5;
  localparam int ST_CH_B = 6;
  localparam int ST_SUPPLY = 7;
  localparam logic [7:0] LIVE_RESET = 8'h00;

  // Bytes from the bit-timing front end
  typedef struct packed {
    logic reset_seen; // Reset pulse seen
    logic byte_valid; // A whole byte arrived
    logic [7:0] data; // Byte, LSB first on the wire
    logic prog_pulse; // Programming pulse applied
  } link_in_t;

  // Bits or bytes returned to the front end
  typedef struct packed {
    logic bit_mode; // 1: search bit and its complement, 0: byte
    logic [7:0] data; // LSB goes out first
  } resp_t;
endpackage : swr_pkg

// *** rtl/single_wire_rom_memory_front.sv ***
/*
  ROM function control, memory and switch front end of a bus-powered dual
  open-drain switch. Assumes a separate bit-timing front end that decodes
  bytes, reset and programming pulses and serialises response words LSB first.
*/
// Behaviour
// RULE1: All bytes travel least significant bit first, both ways.
// RULE2: The 64-bit identity is family code, 48-bit serial, then an 8-bit CRC of the first 56 bits.
// RULE3: The identity CRC uses polynomial x^8+x^5+x^4+1.
// RULE4: The master opens every transaction with one of five ROM function commands.
// RULE5: Memory and switch commands are refused until a ROM function completes.
// RULE6: Data memory is 1024 OTP bits in 4 pages of 32 bytes.
// RULE7: Status memory is 8 bytes, 0 to 6 OTP and 7 volatile.
// RULE8: After power-up status byte 6 is copied into status byte 7.
// RULE9: Writes go through an 8-bit scratchpad and return a CRC16 of address and data before programming; the code's CRC16 also covers the command byte.
// RULE10: The master commits a write with a 12V programming pulse.
// RULE11: In hidden mode only match-identity and conditional search are answered.
// RULE12: Both open-drain outputs can be switched and their pin level read back.
// RULE13: Conditional search takes part only when the selected condition holds.
// RULE14: Power-on status takes effect in byte 7 on the first ROM command after power-up.
// RULE15: Hidden mode is both source select bits zero; conditional search then needs polarity one.
// RULE16: Bytes and events come from a bit-timing front end and responses go back to it.
`timescale 1ns/100ps
module single_wire_rom_memory_front import swr_pkg::*; #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab // Arbitrary value
) (
  input wire logic clk, // 10 MHz clock
  input wire logic reset, // Synchronous, active high power-up reset
  input wire link_in_t link_in, // Events and bytes from the bit front end
  input wire logic search_bit, // Master's chosen search direction bit
  input wire logic search_valid, // Search direction bit strobe
  input wire logic resp_ready, // Front end takes a response word
  input wire logic ext_supply, // External supply present
  input wire logic pin_a_in, // Channel A pin level, asynchronous
  input wire logic pin_b_in, // Channel B pin level, asynchronous
  output resp_t resp_data, // Response word
  output logic resp_valid, // Response word waiting
  output logic switch_channel_a, // Channel A transistor on
  output logic switch_channel_b // Channel B transistor on
);
  // ==========================================================
  // Types and storage
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ROM_CMD = 4'h1, S_ID_OUT = 4'h2, S_MATCH = 4'h3,
    S_SEARCH = 4'h4, S_FUNC = 4'h5, S_ADDR_LO = 4'h6, S_ADDR_HI = 4'h7,
    S_WDATA = 4'h8, S_WCRC = 4'h9, S_WPROG = 4'ha, S_RDATA = 4'hb,
    S_CHAN = 4'hc, S_MUTE = 4'hd
  } state_t;
  state_t state_reg;
  // OTP cells start erased; the factory byte is already programmed
  logic [7:0] data_mem [DATA_BYTES] = '{default: OTP_ERASED}; // RULE6
  logic [7:0] status_otp [STATUS_BYTES-1] = '{5: STATUS5_FACTORY, default: OTP_ERASED}; // RULE7
  logic [7:0] live_reg; // RULE7
  logic pwron_pending_reg;
  logic [7:0] scratch_reg; // RULE9
  logic [15:0] crc16_reg;
  logic [15:0] addr_reg;
  logic [7:0] cmd_reg;
  logic [6:0] bit_reg;
  logic search_phase_reg; // 0: send bit and complement, 1: await dir
  logic match_ok_reg;
  logic rom_done_reg;
  logic activity_reg;
  logic a_s1, a_s2, b_s1, b_s2;
  logic [ID_BITS-1:0] id_code;
  // Two-entry response buffer
  resp_t buf_q [2];
  logic [1:0] buf_cnt;
  logic push;
  resp_t push_word;
  logic buf_full;
  logic [1:0] buf_cnt_next;

  // Reflected CRC-8 over a bit stream
  function automatic logic [7:0] crc8_bits(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < CRC_COVER_BITS; i++) begin
      c = ((c[0] ^ d[i]) ? CRC8_POLY_REFL : 8'h00) ^ {1'b0, c[7:1]}; // RULE3
    end
    return c;
  endfunction : crc8_bits

  // Reflected CRC-16 over one byte
  function automatic logic [15:0] crc16_byte(input logic [15:0] c_in, input logic [7:0] d);
    logic [15:0] c;
    c = c_in;
    for (int i = 0; i < 8; i++) begin
      c = ((c[0] ^ d[i]) ? CRC16_POLY_REFL : 16'h0000) ^ {1'b0, c[15:1]};
    end
    return c;
  endfunction : crc16_byte

  // ==========================================================
  // Identity: family in the low byte so bit 0 leaves first
  localparam logic [55:0] ID_BODY = {SERIAL_NUMBER, FAMILY_CODE};
  assign id_code = {crc8_bits(ID_BODY), ID_BODY}; // RULE2

  // Hidden mode and search condition
  logic hidden;
  logic cond_ok;
  logic cond_src;
  logic [7:0] live_view;
  // The first ROM command is judged with the power-on settings it loads
  assign live_view = pwron_pending_reg ? {live_reg[7], status_otp[STATUS_PWRON_ADDR][6:0]} : live_reg; // RULE14
  assign hidden = !live_view[ST_SRC_LO] && !live_view[ST_SRC_HI]; // RULE15
  always_comb begin
    case ({live_view[ST_SRC_HI], live_view[ST_SRC_LO]})
      2'b01: cond_src = activity_reg; // RULE13
      2'b10: cond_src = live_view[4] ? switch_channel_b : switch_channel_a;
      2'b11: cond_src = live_view[4] ? b_s2 : a_s2;
      default: cond_src = 1'b0;
    endcase
  end
  assign cond_ok = hidden ? live_view[ST_POLARITY] : (cond_src == live_view[ST_POLARITY]); // RULE13 RULE15

  // Pin synchronisers
  always_ff @(posedge clk) begin
    a_s1 <= pin_a_in;
    a_s2 <= a_s1;
    b_s1 <= pin_b_in;
    b_s2 <= b_s1;
  end

  // Activity latch: set wins over the clear by a channel access
  logic a_last, b_last;
  always_ff @(posedge clk) begin
    if (reset) begin
      activity_reg <= 1'b0;
      a_last <= 1'b0;
      b_last <= 1'b0;
    end else begin
      a_last <= a_s2;
      b_last <= b_s2;
      if ((a_last != a_s2) || (b_last != b_s2)) begin
        activity_reg <= 1'b1;
      end else if (state_reg == S_CHAN && push) begin
        activity_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Response buffer: stalls the sequencer when full
  assign buf_full = (buf_cnt == 2'd2);
  assign buf_cnt_next = buf_cnt + 2'((push && !buf_full) ? 1 : 0) - 2'((resp_valid && resp_ready) ? 1 : 0);
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_cnt <= 2'd0;
      resp_valid <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (resp_valid && resp_ready) begin
        buf_q[0] <= buf_q[1];
      end
      if (push && !buf_full) begin
        if (buf_cnt == 2'd0 || (buf_cnt == 2'd1 && resp_ready)) begin
          buf_q[0] <= push_word;
        end else begin
          buf_q[1] <= push_word;
        end
      end
      buf_cnt <= buf_cnt_next;
      resp_valid <= (buf_cnt_next != 2'd0); // Registered copy of the non-empty flag
    end
  end
  assign resp_data = buf_q[0]; // RULE16

  // ==========================================================
  // Live status byte and channel switches
  always_ff @(posedge clk) begin
    if (reset) begin
      live_reg <= LIVE_RESET;
      pwron_pending_reg <= 1'b1;
    end else begin
      if (pwron_pending_reg && state_reg == S_ROM_CMD && link_in.byte_valid) begin
        live_reg[6:0] <= status_otp[STATUS_PWRON_ADDR][6:0]; // RULE8 RULE14
        pwron_pending_reg <= 1'b0;
      end else if (state_reg == S_WDATA && cmd_reg == CMD_WRITE_STATUS && link_in.byte_valid
                   && addr_reg[2:0] == STATUS_LIVE_ADDR) begin
        live_reg[6:0] <= link_in.data[6:0]; // Volatile byte written directly
      end
      live_reg[ST_SUPPLY] <= ext_supply;
    end
  end
  // Switch outputs follow the inverted live channel bits from their own flip-flops
  always_ff @(posedge clk) begin
    if (reset) begin
      switch_channel_a <= 1'b1;
      switch_channel_b <= 1'b1;
    end else begin
      switch_channel_a <= !live_reg[ST_CH_A]; // RULE12
      switch_channel_b <= !live_reg[ST_CH_B]; // RULE12
    end
  end

  // ==========================================================
  // OTP arrays: only a programming pulse lowers bits
  always_ff @(posedge clk) begin
    if (state_reg == S_WPROG && link_in.prog_pulse) begin // RULE10
      if (cmd_reg == CMD_WRITE_MEM && !status_otp[0][addr_reg[6:5]] == 1'b0) begin
        data_mem[addr_reg[6:0]] <= data_mem[addr_reg[6:0]] & scratch_reg;
      end else if (cmd_reg == CMD_WRITE_STATUS && addr_reg[2:0] != STATUS_LIVE_ADDR) begin
        status_otp[addr_reg[2:0]] <= status_otp[addr_reg[2:0]] & scratch_reg;
      end
    end
  end

  // ==========================================================
  // Sequencer
  logic [7:0] read_byte;
  always_comb begin
    if (cmd_reg == CMD_READ_MEM) begin
      read_byte = data_mem[addr_reg[6:0]];
    end else if (addr_reg[2:0] == STATUS_LIVE_ADDR) begin
      read_byte = live_reg;
    end else begin
      read_byte = status_otp[addr_reg[2:0]];
    end
  end
  logic id_bit;
  assign id_bit = id_code[bit_reg[5:0]]; // RULE1

  always_comb begin
    push = 1'b0;
    push_word = '0;
    case (state_reg)
      S_ID_OUT: begin
        push = 1'b1;
        push_word = '{bit_mode: 1'b0, data: id_code[{bit_reg[5:3], 3'b000} +: 8]}; // RULE1 RULE2
      end
      S_SEARCH: begin
        push = !search_phase_reg;
        push_word = '{bit_mode: 1'b1, data: {6'h00, !id_bit, id_bit}};
      end
      S_WCRC: begin
        push = 1'b1;
        push_word = '{bit_mode: 1'b0, data: bit_reg[0] ? ~crc16_reg[15:8] : ~crc16_reg[7:0]}; // RULE9
      end
      S_RDATA: begin
        push = 1'b1;
        push_word = '{bit_mode: 1'b0, data: read_byte};
      end
      S_CHAN: begin
        push = 1'b1;
        push_word = '{bit_mode: 1'b0, data: {live_reg[ST_SUPPLY], activity_reg, b_s2, a_s2, 2'b00,
                                             switch_channel_b, switch_channel_a}}; // RULE12
      end
      default: begin
        push = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset || link_in.reset_seen) begin
      state_reg <= S_ROM_CMD;
      rom_done_reg <= 1'b0;
      bit_reg <= '0;
      cmd_reg <= 8'h00;
      addr_reg <= 16'h0000;
      scratch_reg <= OTP_ERASED;
      crc16_reg <= 16'h0000;
      search_phase_reg <= 1'b0;
      match_ok_reg <= 1'b1;
    end else begin
      case (state_reg)
        S_ROM_CMD: if (link_in.byte_valid) begin // RULE4
          bit_reg <= '0;
          match_ok_reg <= 1'b1;
          search_phase_reg <= 1'b0;
          case (link_in.data)
            CMD_MATCH_ID: state_reg <= S_MATCH; // RULE11
            CMD_COND_SEARCH: state_reg <= cond_ok ? S_SEARCH : S_MUTE; // RULE13
            CMD_READ_ID: state_reg <= hidden ? S_MUTE : S_ID_OUT; // RULE11
            CMD_SEARCH_ID: state_reg <= hidden ? S_MUTE : S_SEARCH; // RULE11
            CMD_SKIP_ID: begin
              state_reg <= hidden ? S_MUTE : S_FUNC;
              rom_done_reg <= !hidden;
            end
            default: state_reg <= S_MUTE;
          endcase
        end
        S_ID_OUT: if (!buf_full) begin
          bit_reg <= bit_reg + 7'd8;
          if (bit_reg == 7'(ID_BITS - 8)) begin
            state_reg <= S_FUNC;
            rom_done_reg <= 1'b1;
          end
        end
        S_MATCH: if (link_in.byte_valid) begin
          bit_reg <= bit_reg + 7'd8;
          if (link_in.data != id_code[{bit_reg[5:3], 3'b000} +: 8]) begin
            state_reg <= S_MUTE;
          end else if (bit_reg == 7'(ID_BITS - 8)) begin
            state_reg <= S_FUNC;
            rom_done_reg <= 1'b1;
          end
        end
        S_SEARCH: begin
          if (!search_phase_reg && !buf_full) begin
            search_phase_reg <= 1'b1;
          end else if (search_phase_reg && search_valid) begin
            search_phase_reg <= 1'b0;
            bit_reg <= bit_reg + 7'd1;
            if (search_bit != id_bit) begin
              state_reg <= S_MUTE;
            end else if (bit_reg == 7'(ID_BITS - 1)) begin
              state_reg <= S_FUNC;
              rom_done_reg <= 1'b1;
            end
          end
        end
        S_FUNC: if (link_in.byte_valid && rom_done_reg) begin // RULE5
          cmd_reg <= link_in.data;
          crc16_reg <= crc16_byte(16'h0000, link_in.data);
          bit_reg <= '0;
          case (link_in.data)
            CMD_READ_MEM, CMD_READ_STATUS, CMD_WRITE_MEM, CMD_WRITE_STATUS: state_reg <= S_ADDR_LO;
            CMD_CHANNEL: state_reg <= S_CHAN;
            default: state_reg <= S_MUTE;
          endcase
        end
        S_ADDR_LO: if (link_in.byte_valid) begin
          addr_reg[7:0] <= link_in.data;
          crc16_reg <= crc16_byte(crc16_reg, link_in.data);
          state_reg <= S_ADDR_HI;
        end
        S_ADDR_HI: if (link_in.byte_valid) begin
          addr_reg[15:8] <= link_in.data;
          crc16_reg <= crc16_byte(crc16_reg, link_in.data);
          state_reg <= (cmd_reg == CMD_WRITE_MEM || cmd_reg == CMD_WRITE_STATUS) ? S_WDATA : S_RDATA;
        end
        S_WDATA: if (link_in.byte_valid) begin
          scratch_reg <= link_in.data; // RULE9
          crc16_reg <= crc16_byte(crc16_reg, link_in.data);
          bit_reg <= '0;
          state_reg <= S_WCRC;
        end
        S_WCRC: if (!buf_full) begin
          bit_reg <= bit_reg + 7'd1;
          if (bit_reg[0]) begin
            state_reg <= S_WPROG;
          end
        end
        S_WPROG: if (link_in.prog_pulse) begin // RULE10
          state_reg <= S_MUTE;
        end
        S_RDATA: if (!buf_full) begin
          addr_reg <= addr_reg + 16'h0001;
        end
        S_CHAN: if (!buf_full) begin
          state_reg <= S_MUTE;
        end
        default: state_reg <= state_reg;
      endcase
    end
  end
endmodule : single_wire_rom_memory_front

// *** dv/swr_props.sv ***
/*
  Port checker for the single-wire ROM and memory front end.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
module swr_props import swr_pkg::*; (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire link_in_t link_in, // Link events
  input wire logic resp_ready, // Word taken
  input wire resp_t resp_data, // Response word
  input wire logic resp_valid, // Word waiting
  input wire logic switch_channel_a, // Switch A
  input wire logic switch_channel_b // Switch B
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Helpers
  logic first_reg;
  logic search_reg;
  logic is_rom;
  logic is_search;
  // Command code classes
  assign is_rom = link_in.data inside {CMD_READ_ID, CMD_MATCH_ID, CMD_SEARCH_ID, CMD_SKIP_ID, CMD_COND_SEARCH};
  assign is_search = link_in.data inside {CMD_SEARCH_ID, CMD_COND_SEARCH};
  // First byte of a transaction still to come
  always_ff @(posedge clk) begin
    if (reset || link_in.reset_seen) first_reg <= 1'b1;
    else if (link_in.byte_valid) first_reg <= 1'b0;
  end
  // Transaction opened by a search
  always_ff @(posedge clk) begin
    if (reset || link_in.reset_seen) search_reg <= 1'b0;
    else if (link_in.byte_valid && first_reg && is_search) search_reg <= 1'b1;
  end
  // ==========================================================
  // Properties
  a_resp_held: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
    else $error("response word changed before it was taken");
  a_reset_empty: assert property (disable iff (1'b0) reset |=> !resp_valid)
    else $error("response buffer not empty after reset");
  a_reset_switches: assert property (disable iff (1'b0) reset |=> switch_channel_a && switch_channel_b)
    else $error("switches not on after reset");
  a_switch_cause: assert property ($changed({switch_channel_a, switch_channel_b}) && !$past(reset) |->
    $past(link_in.byte_valid) || $past(link_in.byte_valid, 2) || $past(link_in.byte_valid, 3))
    else $error("switch moved without a byte");
  a_refuse_first: assert property (link_in.byte_valid && first_reg && !is_rom && !resp_valid |=> !resp_valid [*8])
    else $error("answer to a non ROM first byte");
  a_search_pair: assert property (search_reg && resp_valid && resp_data.bit_mode |->
    resp_data.data[1] == !resp_data.data[0])
    else $error("search word is not a bit and its complement");
  a_prog_mute: assert property (link_in.prog_pulse && !resp_valid |=> !resp_valid [*8])
    else $error("answer after programming pulse");
  a_reset_quiet: assert property (link_in.reset_seen && !resp_valid ##1 !link_in.byte_valid [*2] |=> !resp_valid)
    else $error("answer before a ROM command");
endmodule : swr_props
bind single_wire_rom_memory_front swr_props swr_props_inst (.clk(clk), .reset(reset), .link_in(link_in),
  .resp_ready(resp_ready), .resp_data(resp_data), .resp_valid(resp_valid),
  .switch_channel_a(switch_channel_a), .switch_channel_b(switch_channel_b));

// *** dv/master_model.sv ***
/*
  Bus master and bit front end model: sends bytes and events, takes words.
  Assumes the caller drives it from the clock's rising edge.
*/
`timescale 1ns/100ps
module master_model import swr_pkg::*; (
  input wire logic clk, // Clock
  input wire logic slow, // Stall the response side
  output link_in_t link_in, // Bytes and events
  output logic search_bit, // Chosen direction
  output logic search_valid, // Direction strobe
  output logic resp_ready // Word taken
);
  logic [2:0] stall_reg = 3'h0;
  // Idle values
  initial begin
    link_in = '0;
    search_bit = 1'b0;
    search_valid = 1'b0;
  end
  // Slow mode takes one word in eight cycles
  always @(posedge clk) stall_reg <= stall_reg + 3'h1;
  assign resp_ready = !slow || (stall_reg == 3'h0);
  // One whole byte, a reset or a programming pulse, then idle with the data line scrambled
  task automatic put(input logic [7:0] b, input logic rs, input logic pp);
    @(posedge clk);
    link_in <= {rs, !rs && !pp, b, pp};
    @(posedge clk);
    link_in <= {1'b0, 1'b0, ~b, 1'b0};
    repeat (3) @(posedge clk);
  endtask : put
  // Direction bit of one search step
  task automatic steer(input logic b);
    @(posedge clk);
    search_bit <= b;
    search_valid <= 1'b1;
    @(posedge clk);
    search_valid <= 1'b0;
    search_bit <= ~b;
  endtask : steer
endmodule : master_model

// *** dv/single_wire_rom_memory_front_bench.sv ***
/*
  Self-checking bench for the ROM and memory front end.
  Assumes the master model and the port checker beside it.
*/
`timescale 1ns/100ps
module single_wire_rom_memory_front_bench import swr_pkg::*; ;
  localparam logic [7:0] FAMILY = 8'h3c; // Arbitrary value
  localparam logic [47:0] SERIAL = 48'h9a1e_27c4_5b06; // Arbitrary value
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic ext_supply = 1'b0;
  logic pin_a_in = 1'b0;
  logic pin_b_in = 1'b0;
  link_in_t link_in;
  logic search_bit, search_valid, resp_ready, resp_valid, switch_channel_a, switch_channel_b;
  resp_t resp_data;
  integer n_errors = 0;
  integer num_checks = 0;
  integer seed = 95;
  logic [8:0] exp_q[$];
  logic [8:0] mask_q[$];
  logic [7:0] id_b [8];
  // ==========================================================
  // Clock, pins and instances
  always #50 clk = ~clk;
  always @(posedge clk) begin
    pin_a_in <= 1'($random(seed));
    pin_b_in <= 1'($random(seed));
    ext_supply <= 1'($random(seed));
  end
  single_wire_rom_memory_front #(.FAMILY_CODE(FAMILY), .SERIAL_NUMBER(SERIAL)) single_wire_rom_memory_front_inst (
    .clk(clk), .reset(reset), .link_in(link_in), .search_bit(search_bit), .search_valid(search_valid),
    .resp_ready(resp_ready), .ext_supply(ext_supply), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
    .resp_data(resp_data), .resp_valid(resp_valid), .switch_channel_a(switch_channel_a),
    .switch_channel_b(switch_channel_b));
  master_model master_model_inst (.clk(clk), .slow(slow), .link_in(link_in), .search_bit(search_bit),
    .search_valid(search_valid), .resp_ready(resp_ready));
  // ==========================================================
  // Checking
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic note(input logic [8:0] v, input logic [8:0] m);
    exp_q.push_back(v & m);
    mask_q.push_back(m);
  endtask : note
  // Each word taken is compared with the oldest note
  always @(posedge clk) begin
    if (resp_valid === 1'b1 && resp_ready === 1'b1 && reset === 1'b0) begin
      if (exp_q.size() == 0) check(9'h1ff, 9'h000, "unexpected word");
      else check(resp_data & mask_q.pop_front(), exp_q.pop_front(), "response word");
    end
  end
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic wait_empty(input string name);
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("MISMATCH at %0t: %s timed out", $time, name);
      wrap_up();
    end
  endtask : wait_empty
  task automatic drain(input string name);
    wait_empty(name);
    repeat (20) @(posedge clk);
    $display("Test %s done", name);
  endtask : drain
  task automatic do_reset();
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    check({8'h00, switch_channel_a & switch_channel_b}, 9'h001, "switches after reset");
  endtask : do_reset
  // Reflected CRC, one byte, LSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b, input logic [15:0] p);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? (c >> 1) ^ p : c >> 1;
    return c;
  endfunction : crc_step
  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] crc;
    logic [7:0] msg [4];
    logic b;
    repeat (16) @(posedge clk);
    do_reset();
    id_b[0] = FAMILY;
    for (int i = 1; i < 7; i++) id_b[i] = SERIAL[8*i-8 +: 8];
    crc = 16'h0000;
    for (int i = 0; i < 7; i++) crc = crc_step(crc, id_b[i], {8'h00, CRC8_POLY_REFL});
    id_b[7] = crc[7:0];
    // Function before any ROM command stays unanswered
    master_model_inst.put(8'h00, 1'b1, 1'b0);
    master_model_inst.put(CMD_CHANNEL, 1'b0, 1'b0);
    drain("refused");
    // Identity read with a stalling master
    slow <= 1'b1;
    master_model_inst.put(8'h00, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) note({1'b0, id_b[i]}, 9'h1ff);
    master_model_inst.put(CMD_READ_ID, 1'b0, 1'b0);
    drain("read id");
    slow <= 1'b0;
    // Full search along the own identity
    master_model_inst.put(8'h00, 1'b1, 1'b0);
    note({1'b1, 6'h00, ~id_b[0][0], id_b[0][0]}, 9'h103);
    master_model_inst.put(CMD_SEARCH_ID, 1'b0, 1'b0);
    for (int i = 0; i < 64; i++) begin
      b = id_b[i/8][i%8];
      wait_empty("search");
      if (i < 63) note({1'b1, 6'h00, ~id_b[(i+1)/8][(i+1)%8], id_b[(i+1)/8][(i+1)%8]}, 9'h103);
      master_model_inst.steer(b);
    end
    drain("search");
    // Writes after skip, after a match and after a failed match
    for (int k = 0; k < 3; k++) begin
      msg = '{CMD_WRITE_MEM, {1'b0, 7'($random(seed))}, 8'h00, 8'($random(seed))};
      master_model_inst.put(8'h00, 1'b1, 1'b0);
      master_model_inst.put((k == 0) ? CMD_SKIP_ID : CMD_MATCH_ID, 1'b0, 1'b0);
      for (int j = 0; j < 8 && k > 0; j++) master_model_inst.put(id_b[j] ^ {7'h00, k == 2 && j == 3}, 1'b0, 1'b0);
      crc = 16'h0000;
      for (int j = 0; j < 4; j++) crc = crc_step(crc, msg[j], CRC16_POLY_REFL);
      if (k < 2) note({1'b0, ~crc[7:0]}, 9'h1ff);
      if (k < 2) note({1'b0, ~crc[15:8]}, 9'h1ff);
      for (int j = 0; j < 4; j++) master_model_inst.put(msg[j], 1'b0, 1'b0);
      wait_empty("write");
      master_model_inst.put(8'h00, 1'b0, 1'b1);
      drain("write");
    end
    do_reset();
    wrap_up();
  end
endmodule : single_wire_rom_memory_front_bench
